// ### logic/stfwp_params.svh
// constants for the transmit buffer write port
`ifndef STFWP_PARAMS_SVH
`define STFWP_PARAMS_SVH
`define STFWP_PARTS 8
`define STFWP_LINES 3'h4
`define STFWP_LAST_WORD 2'h3
`define STFWP_ENTRIES 128
`define STFWP_LINE_SLOTS 32
`define STFWP_BE_NONE 4'h0
`define STFWP_F_DATA_HI 31
`define STFWP_F_BE_HI 35
`define STFWP_F_BE_LO 32
`define STFWP_F_SOP 36
`define STFWP_F_EOP 37
`define STFWP_F_ERR 38
`define STFWP_F_PORT_HI 46
`define STFWP_F_PORT_LO 39
`endif

// ### logic/stfwp_pkg.sv
// types shared by the transmit buffer write port
package stfwp_pkg;
  typedef logic [2:0] stfwp_part_t;
  typedef logic [1:0] stfwp_line_t;
  typedef logic [1:0] stfwp_word_t;
  typedef logic [2:0] stfwp_cnt_t;
  typedef logic [46:0] stfwp_entry_t;
endpackage

// ### logic/stfwp_tx_write_port.sv
// transmit buffer: write port, per-partition pointers, scheduler drain port
`timescale 1ns/1ps
`include "stfwp_params.svh"

module stfwp_tx_write_port
(
  // write clock and reset
  input wire logic clk,
  input wire logic rst,
  // user write port
  input wire logic tx_wr_strobe,
  input wire logic [31:0] tx_wr_data,
  input wire logic [3:0] tx_wr_byte_enables,
  input wire logic tx_wr_packet_start,
  input wire logic tx_wr_packet_end,
  input wire logic tx_wr_packet_error,
  input wire logic [7:0] tx_wr_link_port,
  input wire logic [2:0] tx_wr_partition_addr,
  input wire logic tx_wr_line_terminate,
  // fill status
  input wire logic [2:0] tx_fill_threshold,
  output logic tx_partition_full,
  // link scheduler drain port
  input wire logic tx_buffer_link_disable,
  input wire logic sched_poll,
  input wire logic [2:0] sched_partition,
  output logic sched_valid,
  output logic sched_idle,
  output logic [31:0] sched_data,
  output logic [3:0] sched_byte_enables,
  output logic sched_packet_start,
  output logic sched_packet_end,
  output logic sched_packet_error,
  output logic [7:0] sched_link_port,
  output logic sched_line_last
);

  // ==========================================================
  // storage and pointers
  stfwp_pkg::stfwp_entry_t mem [0:`STFWP_ENTRIES-1];
  stfwp_pkg::stfwp_cnt_t line_len [0:`STFWP_LINE_SLOTS-1];
  stfwp_pkg::stfwp_cnt_t cnt [0:`STFWP_PARTS-1];
  stfwp_pkg::stfwp_line_t wr_line [0:`STFWP_PARTS-1];
  stfwp_pkg::stfwp_word_t wr_word [0:`STFWP_PARTS-1];
  stfwp_pkg::stfwp_line_t rd_line [0:`STFWP_PARTS-1];
  stfwp_pkg::stfwp_word_t rd_word [0:`STFWP_PARTS-1];

  logic wr_ok;
  logic wr_close;
  logic rd_ok;
  logic rd_done;
  stfwp_pkg::stfwp_cnt_t close_len;
  stfwp_pkg::stfwp_cnt_t rd_len;
  logic [6:0] wr_idx;
  logic [6:0] rd_idx;
  logic [4:0] wr_slot;
  logic [4:0] rd_slot;

  // ==========================================================
  // write decode
  // a completely full partition has no free line, so words are dropped
  always_comb
  begin
    wr_ok = tx_wr_strobe
      && (tx_wr_byte_enables != `STFWP_BE_NONE)
      && (cnt[tx_wr_partition_addr] < `STFWP_LINES);
    // a terminate with nothing pending in the line does not make an
    // empty line, the pointer is already at a fresh line
    wr_close = (wr_ok && (tx_wr_packet_end
      || wr_word[tx_wr_partition_addr] == `STFWP_LAST_WORD))
      || (tx_wr_line_terminate
      && (wr_ok || wr_word[tx_wr_partition_addr] != 2'h0));
    close_len = {1'b0, wr_word[tx_wr_partition_addr]} + {2'h0, wr_ok};
    wr_slot = {tx_wr_partition_addr, wr_line[tx_wr_partition_addr]};
    wr_idx = {wr_slot, wr_word[tx_wr_partition_addr]};
  end

  // ==========================================================
  // drain decode
  always_comb
  begin
    rd_ok = sched_poll && !tx_buffer_link_disable
      && (cnt[sched_partition] != 3'h0);
    rd_slot = {sched_partition, rd_line[sched_partition]};
    rd_idx = {rd_slot, rd_word[sched_partition]};
    rd_len = line_len[rd_slot];
    rd_done = rd_ok
      && ({1'b0, rd_word[sched_partition]} == rd_len - 3'h1);
  end

  // word storage; tags and port number ride with the data
  always_ff @(posedge clk)
  begin
    if (wr_ok)
    begin
      mem[wr_idx] <= {tx_wr_link_port, tx_wr_packet_error,
        tx_wr_packet_end, tx_wr_packet_start, tx_wr_byte_enables,
        tx_wr_data};
    end
  end

  // line length is fixed when the line closes
  always_ff @(posedge clk)
  begin
    if (wr_close)
    begin
      line_len[wr_slot] <= close_len;
    end
  end

  // ==========================================================
  // per-partition pointers and occupancy
  // only closed lines are counted, so the reader never sees a half line
  for (genvar i = 0; i < `STFWP_PARTS; i++)
  begin : g_part
    logic inc;
    logic dec;
    logic hit_wr;
    assign hit_wr = (tx_wr_partition_addr == 3'(i));
    assign inc = wr_close && hit_wr;
    assign dec = rd_done && (sched_partition == 3'(i));

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        cnt[i] <= 3'h0;
        wr_line[i] <= 2'h0;
        wr_word[i] <= 2'h0;
      end
      else
      begin
        cnt[i] <= cnt[i] + {2'h0, inc} - {2'h0, dec};
        if (inc)
        begin
          wr_line[i] <= wr_line[i] + 2'h1;
          wr_word[i] <= 2'h0;
        end
        else if (wr_ok && hit_wr)
        begin
          wr_word[i] <= wr_word[i] + 2'h1;
        end
      end
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        rd_line[i] <= 2'h0;
        rd_word[i] <= 2'h0;
      end
      else if (dec)
      begin
        rd_line[i] <= rd_line[i] + 2'h1;
        rd_word[i] <= 2'h0;
      end
      else if (rd_ok && sched_partition == 3'(i))
      begin
        rd_word[i] <= rd_word[i] + 2'h1;
      end
    end
  end

  // ==========================================================
  // full flag for the addressed partition, one cycle behind the address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_partition_full <= 1'b0;
    end
    else
    begin
      tx_partition_full <=
        (cnt[tx_wr_partition_addr] > tx_fill_threshold);
    end
  end

  // ==========================================================
  // drain outputs; idle whenever no word goes out, disable included
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sched_valid <= 1'b0;
      sched_idle <= 1'b1;
      sched_data <= 32'h0000_0000;
      sched_byte_enables <= 4'h0;
      sched_packet_start <= 1'b0;
      sched_packet_end <= 1'b0;
      sched_packet_error <= 1'b0;
      sched_link_port <= 8'h00;
      sched_line_last <= 1'b0;
    end
    else
    begin
      sched_valid <= rd_ok;
      sched_idle <= !rd_ok;
      sched_line_last <= rd_done;
      if (rd_ok)
      begin
        sched_data <= mem[rd_idx][`STFWP_F_DATA_HI:0];
        sched_byte_enables <= mem[rd_idx][`STFWP_F_BE_HI:`STFWP_F_BE_LO];
        sched_packet_start <= mem[rd_idx][`STFWP_F_SOP];
        sched_packet_end <= mem[rd_idx][`STFWP_F_EOP];
        sched_packet_error <= mem[rd_idx][`STFWP_F_ERR];
        sched_link_port <= mem[rd_idx][`STFWP_F_PORT_HI:`STFWP_F_PORT_LO];
      end
    end
  end

  // ==========================================================
  // checks
  eop_advance_a: assert property (@(posedge clk) disable iff (rst)
    (wr_ok && tx_wr_packet_end)
    |=> wr_word[$past(tx_wr_partition_addr)] == 2'h0)
    else $error("packet end did not close the line");

  strobe_low_a: assert property (@(posedge clk) disable iff (rst)
    (!tx_wr_strobe && !tx_wr_line_terminate)
    |=> wr_word[$past(tx_wr_partition_addr)]
      == $past(wr_word[tx_wr_partition_addr]))
    else $error("word taken without strobe");

  drop_empty_a: assert property (@(posedge clk) disable iff (rst)
    (tx_wr_byte_enables == 4'h0 && !tx_wr_line_terminate)
    |=> cnt[$past(tx_wr_partition_addr)]
      <= $past(cnt[tx_wr_partition_addr]))
    else $error("empty enable word was written");

  terminate_a: assert property (@(posedge clk) disable iff (rst)
    (tx_wr_line_terminate && !tx_wr_strobe
      && wr_word[tx_wr_partition_addr] != 2'h0)
    |=> wr_word[$past(tx_wr_partition_addr)] == 2'h0)
    else $error("terminate did not move to next line");

  disable_idle_a: assert property (@(posedge clk) disable iff (rst)
    tx_buffer_link_disable |=> sched_idle && !sched_valid)
    else $error("data sent while disabled");

  disable_hold_a: assert property (@(posedge clk) disable iff (rst)
    tx_buffer_link_disable [*3] |-> !sched_valid && !$past(sched_valid))
    else $error("port serviced while disabled");

  disabled_fill_a: assert property (@(posedge clk) disable iff (rst)
    (tx_buffer_link_disable && wr_close)
    |=> cnt[$past(tx_wr_partition_addr)]
      == $past(cnt[tx_wr_partition_addr]) + 3'h1)
    else $error("disabled buffer lost fill status");

  full_flag_a: assert property (@(posedge clk) disable iff (rst)
    (cnt[tx_wr_partition_addr] > tx_fill_threshold)
    |=> tx_partition_full)
    else $error("full flag missing above threshold");

endmodule

// ### verif/stfwp_writer.sv
// behavioural user-side writer that feeds packets into the port
`timescale 1ns/1ps
module stfwp_writer
(
  // write clock
  input wire logic clk,
  // user write port
  output logic tx_wr_strobe,
  output logic [31:0] tx_wr_data,
  output logic [3:0] tx_wr_byte_enables,
  output logic tx_wr_packet_start,
  output logic tx_wr_packet_end,
  output logic tx_wr_packet_error,
  output logic [7:0] tx_wr_link_port,
  output logic [2:0] tx_wr_partition_addr,
  output logic tx_wr_line_terminate
);
  // ====================================================
  // idle until the first packet
  initial
  begin
    {tx_wr_strobe, tx_wr_data, tx_wr_byte_enables} = '0;
    {tx_wr_packet_start, tx_wr_packet_end, tx_wr_packet_error} = '0;
    {tx_wr_link_port, tx_wr_partition_addr, tx_wr_line_terminate} = '0;
  end
  // one packet of n words; last word gets be, or a terminate pulse
  task automatic send(input logic [2:0] pt, input logic [7:0] pn,
    input int n, input logic er, input logic [3:0] be, input logic tm);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      tx_wr_strobe = 1'b1;
      tx_wr_partition_addr = pt;
      tx_wr_link_port = pn;
      tx_wr_data = {pn, 13'h0, pt, i[7:0]};
      tx_wr_packet_start = (i % 4 == 0);
      tx_wr_packet_end = (i == n - 1) && !tm;
      tx_wr_packet_error = er && tx_wr_packet_end;
      tx_wr_byte_enables = (i == n - 1) ? be : 4'hf;
      tx_wr_line_terminate = (i == n - 1) && tm;
    end
    @(negedge clk);
    // released data lines hold the inverse of the last word, never the last word
    tx_wr_data = ~tx_wr_data;
    {tx_wr_strobe, tx_wr_line_terminate, tx_wr_packet_end} = '0;
  endtask
  // bare terminate pulse with no word alongside it
  task automatic cut(input logic [2:0] pt);
    @(negedge clk);
    tx_wr_partition_addr = pt;
    tx_wr_line_terminate = 1'b1;
    @(negedge clk);
    tx_wr_line_terminate = 1'b0;
  endtask
endmodule

// ### verif/stfwp_tx_write_port_tb.sv
// self-checking bench for the transmit buffer write port
`timescale 1ns/1ps
module stfwp_tx_write_port_tb;
  // ====================================================
  // clock, reset and scheduler side
  logic clk = 0;
  logic rst = 1;
  logic tx_buffer_link_disable = 0;
  logic sched_poll = 0;
  logic [2:0] sched_partition = 3'h0;
  logic [2:0] tx_fill_threshold = 3'h7;
  logic tx_wr_strobe, tx_wr_packet_start, tx_wr_packet_end;
  logic tx_wr_packet_error, tx_wr_line_terminate;
  logic [31:0] tx_wr_data;
  logic [3:0] tx_wr_byte_enables;
  logic [7:0] tx_wr_link_port;
  logic [2:0] tx_wr_partition_addr;
  logic tx_partition_full, sched_valid, sched_idle, sched_line_last;
  logic sched_packet_start, sched_packet_end, sched_packet_error;
  logic [31:0] sched_data;
  logic [3:0] sched_byte_enables;
  logic [7:0] sched_link_port;
  int fail_count = 0;
  int checked = 0;
  wire [3:0] flags = {sched_packet_start, sched_packet_end,
    sched_packet_error, sched_line_last};
  always #20 clk = ~clk;
  // ====================================================
  // partner and design
  stfwp_writer u_stfwp_writer (.clk(clk), .tx_wr_strobe(tx_wr_strobe),
    .tx_wr_data(tx_wr_data), .tx_wr_byte_enables(tx_wr_byte_enables),
    .tx_wr_packet_start(tx_wr_packet_start),
    .tx_wr_packet_end(tx_wr_packet_end),
    .tx_wr_packet_error(tx_wr_packet_error),
    .tx_wr_link_port(tx_wr_link_port),
    .tx_wr_partition_addr(tx_wr_partition_addr),
    .tx_wr_line_terminate(tx_wr_line_terminate));
  stfwp_tx_write_port u_stfwp_tx_write_port (.clk(clk), .rst(rst),
    .tx_wr_strobe(tx_wr_strobe), .tx_wr_data(tx_wr_data),
    .tx_wr_byte_enables(tx_wr_byte_enables),
    .tx_wr_packet_start(tx_wr_packet_start),
    .tx_wr_packet_end(tx_wr_packet_end),
    .tx_wr_packet_error(tx_wr_packet_error),
    .tx_wr_link_port(tx_wr_link_port),
    .tx_wr_partition_addr(tx_wr_partition_addr),
    .tx_wr_line_terminate(tx_wr_line_terminate),
    .tx_fill_threshold(tx_fill_threshold),
    .tx_partition_full(tx_partition_full),
    .tx_buffer_link_disable(tx_buffer_link_disable),
    .sched_poll(sched_poll), .sched_partition(sched_partition),
    .sched_valid(sched_valid), .sched_idle(sched_idle),
    .sched_data(sched_data), .sched_byte_enables(sched_byte_enables),
    .sched_packet_start(sched_packet_start),
    .sched_packet_end(sched_packet_end),
    .sched_packet_error(sched_packet_error),
    .sched_link_port(sched_link_port), .sched_line_last(sched_line_last));
  // ====================================================
  // shared checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // poll one word; f = {valid, start, end, error, line last}
  task automatic take(input logic [2:0] p, input logic [31:0] d,
    input logic [4:0] f, input logic [3:0] be);
    @(negedge clk);
    sched_poll = 1'b1;
    sched_partition = p;
    @(negedge clk);
    // valid, idle and line last stand for this one cycle only
    sched_poll = 1'b0;
    chk(sched_valid, f[4]);
    chk(sched_idle, !f[4]);
    if (f[4])
    begin
      chk(sched_data, d);
      chk(flags, f[3:0]);
      chk(sched_link_port, d[31:24]);
      chk(sched_byte_enables, be);
    end
  endtask
  // the closing verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ====================================================
  // scenarios
  // dropped word, then a six-word packet spilling into a short line
  task automatic t_packet();
    u_stfwp_writer.send(3'h2, 8'h5a, 1, 1'b0, 4'h0, 1'b0);
    u_stfwp_writer.send(3'h2, 8'h5a, 6, 1'b1, 4'hc, 1'b0);
    for (int i = 0; i < 6; i++)
      take(3'h2, {8'h5a, 13'h0, 3'h2, i[7:0]}, {1'b1, i % 4 == 0, i == 5,
        i == 5, i == 3 || i == 5}, (i == 5) ? 4'hc : 4'hf);
    take(3'h2, 32'h0, 5'h00, 4'h0);
  endtask
  // terminate pulse closes a line that has no packet end
  task automatic t_term();
    u_stfwp_writer.send(3'h3, 8'h21, 2, 1'b0, 4'hf, 1'b1);
    take(3'h3, 32'h2100_0300, 5'b1_1000, 4'hf);
    take(3'h3, 32'h2100_0301, 5'b1_0001, 4'hf);
    // open line left by a dropped end word, closed by a bare terminate
    u_stfwp_writer.send(3'h3, 8'h21, 2, 1'b0, 4'h0, 1'b0);
    u_stfwp_writer.cut(3'h3);
    take(3'h3, 32'h2100_0300, 5'b1_1001, 4'hf);
  endtask
  // disabled buffer still fills; full follows threshold and address
  task automatic t_disable();
    tx_fill_threshold = 3'h1;
    tx_buffer_link_disable = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      u_stfwp_writer.send(3'h4, 8'h44, 1, 1'b0, 4'hf, 1'b0);
      repeat (2) @(negedge clk);
      chk(tx_partition_full, k == 1);
    end
    take(3'h4, 32'h0, 5'h00, 4'h0);
    u_stfwp_writer.send(3'h5, 8'h00, 1, 1'b0, 4'h0, 1'b0);
    repeat (2) @(negedge clk);
    chk(tx_partition_full, 1'b0);
    tx_buffer_link_disable = 1'b0;
    take(3'h4, 32'h4400_0400, 5'b1_1101, 4'hf);
  endtask
  // ====================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_packet();
    t_term();
    t_disable();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
